// >>> rtl/oag_operand_address_generator.sv
// Top of the operand address generator.
`timescale 1ns/100ps
module oag_operand_address_generator (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic srst_i,
  // Decoded operand request.
  input wire oag_pkg::oag_req_t req_i,
  // Register contents read by the core for the named register or pair.
  input wire logic [15:0] reg_data_i,
  // Index register contents for indexed modes.
  input wire logic [15:0] index_data_i,
  // Core state.
  input wire logic [7:0] working_pointer_zero_i,
  input wire logic [7:0] working_pointer_one_i,
  input wire logic [7:0] register_page_pointer_i,
  input wire logic [15:0] next_pc_i,
  input wire logic stack_load_i,
  input wire logic [7:0] stack_load_value_i,
  // Resolved operand, stack pointer and working register address.
  output oag_pkg::oag_res_t res_o,
  output logic [7:0] stack_pointer_low_o,
  output logic [7:0] work_addr_o
);

  logic [7:0] work_addr;
  logic [7:0] stack_addr;
  logic [7:0] sp_now;
  logic push_go;
  logic pop_go;
  logic [15:0] rel_ext;
  logic [15:0] short_ext;
  logic [7:0] reg_indexed;
  oag_pkg::oag_res_t res;
  oag_pkg::oag_res_t next_res;
  logic [7:0] sp_q;

  // Working register address for the short register field.
  oag_work_map u_work_map (
    .reg_field_i(req_i.reg_field),
    .working_pointer_zero_i(working_pointer_zero_i),
    .working_pointer_one_i(working_pointer_one_i),
    .reg_addr_o(work_addr)
  );

  // Stack stepping only on accepted push or pop requests.
  assign push_go = req_i.valid && (req_i.mode == oag_pkg::OAG_STACK_MODE)
                   && (req_i.op == oag_pkg::OAG_PUSH_OP);
  assign pop_go = req_i.valid && (req_i.mode == oag_pkg::OAG_STACK_MODE)
                  && (req_i.op == oag_pkg::OAG_POP_OP);

  oag_stack_ptr u_stack_ptr (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .load_i(stack_load_i),
    .load_value_i(stack_load_value_i),
    .push_i(push_go),
    .pop_i(pop_go),
    .stack_pointer_low_o(sp_now),
    .access_addr_o(stack_addr)
  );

  assign rel_ext = {{8{req_i.operand_field[7]}}, req_i.operand_field[7:0]};
  assign short_ext = req_i.short_offset ? rel_ext : req_i.operand_field;
  assign reg_indexed = req_i.operand_field[7:0] + index_data_i[7:0];

  // Selecting the address per mode is one flat case so each mode's timing
  // is the same single registered cycle.
  always_comb begin
    next_res = '0;
    next_res.valid = req_i.valid;
    unique case (req_i.mode)
      oag_pkg::OAG_REGISTER_MODE: begin
        next_res.space = oag_pkg::OAG_SPACE_VALUE;
        next_res.value = req_i.pair ? reg_data_i : {8'h00, reg_data_i[7:0]};
        next_res.address = req_i.working ? {8'h00, work_addr} : {8'h00, req_i.reg_field};
      end
      oag_pkg::OAG_INDIRECT_REGISTER_MODE: begin
        if (req_i.pair) begin
          next_res.address = reg_data_i;
          if (req_i.op == oag_pkg::OAG_PROGRAM_MEMORY_LOAD_OP) begin
            next_res.space = oag_pkg::OAG_SPACE_PROGRAM;
          end else begin
            next_res.space = oag_pkg::OAG_SPACE_EXTERNAL;
          end
        end else begin
          next_res.address = {8'h00, reg_data_i[7:0]};
          next_res.space = oag_pkg::OAG_SPACE_REGISTER;
          next_res.blocked = (reg_data_i[7:0] >= oag_pkg::OAG_SYS_AREA_BASE);
        end
      end
      oag_pkg::OAG_INDEXED_MODE: begin
        if (req_i.op == oag_pkg::OAG_REGISTER_LOAD_OP) begin
          next_res.address = {8'h00, reg_indexed};
          next_res.space = oag_pkg::OAG_SPACE_REGISTER;
          next_res.blocked = (reg_indexed >= oag_pkg::OAG_SYS_AREA_BASE);
        end else if ((req_i.op == oag_pkg::OAG_PROGRAM_MEMORY_LOAD_OP)
                     || (req_i.op == oag_pkg::OAG_EXTERNAL_DATA_LOAD_OP)) begin
          next_res.address = index_data_i + short_ext;
          if (req_i.op == oag_pkg::OAG_PROGRAM_MEMORY_LOAD_OP) begin
            next_res.space = oag_pkg::OAG_SPACE_PROGRAM;
          end else begin
            next_res.space = oag_pkg::OAG_SPACE_EXTERNAL;
          end
        end else begin
          next_res.blocked = 1'b1;
        end
      end
      oag_pkg::OAG_DIRECT_ADDRESS_MODE: begin
        next_res.address = req_i.operand_field;
        if ((req_i.op == oag_pkg::OAG_ABSOLUTE_JUMP_OP) || (req_i.op == oag_pkg::OAG_CALL_OP)) begin
          next_res.space = oag_pkg::OAG_SPACE_PC;
        end else if (req_i.op == oag_pkg::OAG_PROGRAM_MEMORY_LOAD_OP) begin
          next_res.space = oag_pkg::OAG_SPACE_PROGRAM;
        end else if (req_i.op == oag_pkg::OAG_EXTERNAL_DATA_LOAD_OP) begin
          next_res.space = oag_pkg::OAG_SPACE_EXTERNAL;
        end else begin
          next_res.blocked = 1'b1;
        end
      end
      oag_pkg::OAG_INDIRECT_ADDRESS_MODE: begin
        next_res.address = {oag_pkg::OAG_IA_PAGE_HIGH, req_i.operand_field[7:0]};
        next_res.space = oag_pkg::OAG_SPACE_PROGRAM;
        next_res.blocked = (req_i.op != oag_pkg::OAG_CALL_OP);
      end
      oag_pkg::OAG_RELATIVE_ADDRESS_MODE: begin
        next_res.address = next_pc_i + rel_ext;
        next_res.space = oag_pkg::OAG_SPACE_PC;
        unique case (req_i.op)
          oag_pkg::OAG_BIT_FALSE_BRANCH_OP,
          oag_pkg::OAG_BIT_TRUE_BRANCH_OP,
          oag_pkg::OAG_DECREMENT_BRANCH_NONZERO_OP,
          oag_pkg::OAG_COMPARE_INC_BRANCH_EQUAL_OP,
          oag_pkg::OAG_COMPARE_INC_BRANCH_UNEQUAL_OP,
          oag_pkg::OAG_SHORT_RELATIVE_JUMP_OP: next_res.blocked = 1'b0;
          default: next_res.blocked = 1'b1;
        endcase
      end
      oag_pkg::OAG_IMMEDIATE_OPERAND_MODE: begin
        next_res.space = oag_pkg::OAG_SPACE_VALUE;
        next_res.value = req_i.pair ? req_i.operand_field : {8'h00, req_i.operand_field[7:0]};
      end
      oag_pkg::OAG_STACK_MODE: begin
        next_res.space = oag_pkg::OAG_SPACE_REGISTER;
        next_res.address = {8'h00, stack_addr};
        next_res.stack_write = push_go;
        next_res.blocked = !(push_go || pop_go);
      end
    endcase
    // The page pointer is carried in the value of register-space results so
    // the register file can select its page without a second lookup.
    if (next_res.space == oag_pkg::OAG_SPACE_REGISTER) begin
      next_res.value = {register_page_pointer_i, 8'h00};
    end
  end

  // Results are registered so every output is a flip-flop.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      res <= '0;
      sp_q <= oag_pkg::OAG_STACK_RESET;
      work_addr_o <= 8'h00;
    end else begin
      res <= next_res;
      sp_q <= sp_now;
      work_addr_o <= work_addr;
    end
  end

  assign res_o = res;
  assign stack_pointer_low_o = sp_q;

endmodule // oag_operand_address_generator

// >>> rtl/oag_pkg.sv
// Package of constants and carrier types for the operand address generator.
package oag_pkg;

  // Addressing modes.
  typedef enum logic [2:0] {
    OAG_REGISTER_MODE = 3'h0,
    OAG_INDIRECT_REGISTER_MODE = 3'h1,
    OAG_INDEXED_MODE = 3'h2,
    OAG_DIRECT_ADDRESS_MODE = 3'h3,
    OAG_INDIRECT_ADDRESS_MODE = 3'h4,
    OAG_RELATIVE_ADDRESS_MODE = 3'h5,
    OAG_IMMEDIATE_OPERAND_MODE = 3'h6,
    OAG_STACK_MODE = 3'h7
  } oag_mode_t;

  // Instruction classes that matter for address generation.
  typedef enum logic [3:0] {
    OAG_REGISTER_LOAD_OP = 4'h0,
    OAG_PROGRAM_MEMORY_LOAD_OP = 4'h1,
    OAG_EXTERNAL_DATA_LOAD_OP = 4'h2,
    OAG_ABSOLUTE_JUMP_OP = 4'h3,
    OAG_CALL_OP = 4'h4,
    OAG_BIT_FALSE_BRANCH_OP = 4'h5,
    OAG_BIT_TRUE_BRANCH_OP = 4'h6,
    OAG_DECREMENT_BRANCH_NONZERO_OP = 4'h7,
    OAG_COMPARE_INC_BRANCH_EQUAL_OP = 4'h8,
    OAG_COMPARE_INC_BRANCH_UNEQUAL_OP = 4'h9,
    OAG_SHORT_RELATIVE_JUMP_OP = 4'ha,
    OAG_PUSH_OP = 4'hb,
    OAG_POP_OP = 4'hc,
    OAG_OTHER_OP = 4'hd
  } oag_op_t;

  // Target spaces of the resolved address.
  typedef enum logic [2:0] {
    OAG_SPACE_NONE = 3'h0,
    OAG_SPACE_REGISTER = 3'h1,
    OAG_SPACE_PROGRAM = 3'h2,
    OAG_SPACE_EXTERNAL = 3'h3,
    OAG_SPACE_PC = 3'h4,
    OAG_SPACE_VALUE = 3'h5
  } oag_space_t;

  // Constants of the working register, stack, system area and indirect address arithmetic.
  localparam logic [7:0] OAG_STACK_RESET = 8'hff;
  localparam logic [7:0] OAG_STACK_STEP = 8'h01;
  localparam logic [7:0] OAG_SYS_AREA_BASE = 8'hc0;
  localparam logic [7:0] OAG_WORK_PREFIX_8BIT = 8'hc0;
  localparam logic [7:0] OAG_IA_PAGE_HIGH = 8'h00;
  localparam int OAG_SLICE_HI = 7;
  localparam int OAG_SLICE_LO = 3;
  localparam int OAG_PTR_SEL_BIT = 3;

  // Decoded request for one operand.
  typedef struct packed {
    logic valid;
    oag_mode_t mode;
    oag_op_t op;
    logic working;
    logic pair;
    logic short_offset;
    logic to_external;
    logic [7:0] reg_field;
    logic [15:0] operand_field;
  } oag_req_t;

  // Resolved operand.
  typedef struct packed {
    logic valid;
    oag_space_t space;
    logic blocked;
    logic [15:0] address;
    logic [15:0] value;
    logic stack_write;
  } oag_res_t;

endpackage : oag_pkg

// >>> rtl/oag_stack_ptr.sv
// Stack low pointer with push and pop stepping.
`timescale 1ns/100ps
module oag_stack_ptr (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic srst_i,
  // Load and step controls.
  input wire logic load_i,
  input wire logic [7:0] load_value_i,
  input wire logic push_i,
  input wire logic pop_i,
  // Current pointer and address for this access.
  output logic [7:0] stack_pointer_low_o,
  output logic [7:0] access_addr_o
);

  logic [7:0] stack_pointer_low;
  logic [7:0] next_stack_pointer_low;

  always_comb begin
    access_addr_o = stack_pointer_low;
    next_stack_pointer_low = stack_pointer_low;
    if (load_i) begin
      next_stack_pointer_low = load_value_i;
    end else if (push_i) begin
      access_addr_o = stack_pointer_low - oag_pkg::OAG_STACK_STEP;
      next_stack_pointer_low = stack_pointer_low - oag_pkg::OAG_STACK_STEP;
    end else if (pop_i) begin
      // Read at the current top, step up afterwards.
      next_stack_pointer_low = stack_pointer_low + oag_pkg::OAG_STACK_STEP;
    end
  end

  // Reset sets the pointer so the first push lands one below the top.
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      stack_pointer_low <= oag_pkg::OAG_STACK_RESET;
    end else begin
      stack_pointer_low <= next_stack_pointer_low;
    end
  end

  assign stack_pointer_low_o = stack_pointer_low;

endmodule // oag_stack_ptr

// >>> rtl/oag_work_map.sv
// Working register address mapper.
`timescale 1ns/100ps
module oag_work_map (
  // Short address and pointers.
  input wire logic [7:0] reg_field_i,
  input wire logic [7:0] working_pointer_zero_i,
  input wire logic [7:0] working_pointer_one_i,
  // Full register address.
  output logic [7:0] reg_addr_o
);

  always_comb begin
    if (reg_field_i[oag_pkg::OAG_PTR_SEL_BIT]) begin
      reg_addr_o = {working_pointer_one_i[oag_pkg::OAG_SLICE_HI:oag_pkg::OAG_SLICE_LO],
                    reg_field_i[2:0]};
    end else begin
      reg_addr_o = {working_pointer_zero_i[oag_pkg::OAG_SLICE_HI:oag_pkg::OAG_SLICE_LO],
                    reg_field_i[2:0]};
    end
  end

endmodule // oag_work_map

// >>> verification/oag_operand_address_generator_asserts.sv
// Checker of the operand address generator port behaviour.
`timescale 1ns/100ps
module oag_operand_address_generator_asserts (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic srst_i,
  // Watched ports.
  input wire oag_pkg::oag_req_t req_i,
  input wire logic [15:0] reg_data_i,
  input wire logic [15:0] index_data_i,
  input wire logic [15:0] next_pc_i,
  input wire logic stack_load_i,
  input wire oag_pkg::oag_res_t res_o,
  input wire logic [7:0] stack_pointer_low_o
);
  logic push, pop, rel, ia, idx_blk, ir_blk;
  logic [15:0] rel_sum;
  logic [7:0] idx_sum;
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // Request classes; a stack load wins over stepping, so it is left out.
  always_comb begin
    push = req_i.valid && req_i.op == oag_pkg::OAG_PUSH_OP && !stack_load_i;
    pop = req_i.valid && req_i.op == oag_pkg::OAG_POP_OP && !stack_load_i;
    push = push && req_i.mode == oag_pkg::OAG_STACK_MODE;
    pop = pop && req_i.mode == oag_pkg::OAG_STACK_MODE;
    rel = req_i.valid && req_i.mode == oag_pkg::OAG_RELATIVE_ADDRESS_MODE;
    ia = req_i.valid && req_i.mode == oag_pkg::OAG_INDIRECT_ADDRESS_MODE;
    rel_sum = next_pc_i + {{8{req_i.operand_field[7]}}, req_i.operand_field[7:0]};
    idx_sum = req_i.operand_field[7:0] + index_data_i[7:0];
    idx_blk = req_i.valid && req_i.mode == oag_pkg::OAG_INDEXED_MODE && !req_i.pair;
    idx_blk = idx_blk && req_i.op == oag_pkg::OAG_REGISTER_LOAD_OP && idx_sum >= 8'hc0;
    ir_blk = req_i.valid && req_i.mode == oag_pkg::OAG_INDIRECT_REGISTER_MODE;
    ir_blk = ir_blk && !req_i.pair && reg_data_i[7:0] >= 8'hc0;
  end
  a_push_pre_dec: assert property (push |-> ##2 stack_pointer_low_o == $past(res_o.address[7:0]))
    else $error("push address is not the new stack pointer");
  a_pop_post_inc: assert property (pop |-> ##2 stack_pointer_low_o == $past(res_o.address[7:0]) + 8'h01)
    else $error("pop did not step the pointer up by one");
  a_push_write_reg: assert property (push |=> res_o.stack_write && res_o.space == oag_pkg::OAG_SPACE_REGISTER)
    else $error("push is not a register write");
  a_rel_target: assert property (rel && req_i.op inside {[4'h5:4'ha]} |=> res_o.address == $past(rel_sum))
    else $error("relative target wrong");
  a_ia_low_page: assert property (ia && req_i.op == oag_pkg::OAG_CALL_OP |=> res_o.address == {8'h00, $past(req_i.operand_field[7:0])})
    else $error("indirect pointer not in low page");
  a_ia_call_only: assert property (ia && req_i.op != oag_pkg::OAG_CALL_OP |=> res_o.blocked)
    else $error("indirect address accepted for non call");
  a_ir_sys_block: assert property (ir_blk |=> res_o.blocked)
    else $error("indirect register reached system area");
  a_idx_sys_block: assert property (idx_blk |=> res_o.blocked)
    else $error("indexed access reached system area");
  a_direct_jump: assert property (req_i.valid && req_i.mode == oag_pkg::OAG_DIRECT_ADDRESS_MODE
    && req_i.op == oag_pkg::OAG_ABSOLUTE_JUMP_OP |=> res_o.address == $past(req_i.operand_field))
    else $error("direct jump address wrong");
  c_push: cover property (push ##1 push);
  c_pop: cover property (pop ##1 pop);
  c_rel: cover property (rel);
endmodule // oag_operand_address_generator_asserts
bind oag_operand_address_generator oag_operand_address_generator_asserts u_asserts (
  .clock_i(clock_i),
  .srst_i(srst_i),
  .req_i(req_i),
  .reg_data_i(reg_data_i),
  .index_data_i(index_data_i),
  .next_pc_i(next_pc_i),
  .stack_load_i(stack_load_i),
  .res_o(res_o),
  .stack_pointer_low_o(stack_pointer_low_o)
);

// >>> verification/oag_regfile_model.sv
// Behavioural model of the core register file read port.
`timescale 1ns/100ps
module oag_regfile_model (
  // Named register and its contents.
  input wire logic [7:0] reg_field_i,
  output logic [15:0] reg_data_o
);
  // The high byte differs from the low byte so a byte read cannot pass for a pair.
  assign reg_data_o = {reg_field_i ^ 8'h5a, reg_field_i};
endmodule // oag_regfile_model

// >>> verification/operand_address_generator_tb.sv
// Self-checking testbench of the operand address generator.
`timescale 1ns/100ps
module operand_address_generator_tb;
  typedef struct packed {
    logic [2:0] m;
    logic [3:0] o;
    logic [3:0] fl;
    logic [7:0] rf;
    logic [15:0] opf;
    logic [15:0] ix;
    logic [15:0] e;
  } oag_row_t;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic stack_load_i = 1'b0;
  oag_pkg::oag_req_t req = '0;
  oag_pkg::oag_res_t res_o;
  logic [15:0] reg_data, index_data, seen;
  logic [7:0] sp_o, work_addr;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  oag_row_t r;
  // Flags: bit0 pair, bit1 short offset, bits 3:2 pick the result to compare.
  oag_row_t rows [23] = '{
    '{3'h3, 4'h3, 4'h0, 8'h00, 16'h1234, 16'h0000, 16'h1234}, '{3'h3, 4'h1, 4'h0, 8'h00,
    16'h8000, 16'h0000, 16'h8000}, '{3'h3, 4'h2, 4'h0, 8'h00, 16'h4321, 16'h0000, 16'h4321},
    '{3'h4, 4'h4, 4'h0, 8'h00, 16'hff40, 16'h0000, 16'h0040},
    '{3'h4, 4'h3, 4'h8, 8'h00, 16'h0010, 16'h0000, 16'h0001},
    '{3'h5, 4'h5, 4'h0, 8'h00, 16'h0001, 16'h0000, 16'h1001},
    '{3'h5, 4'h6, 4'h0, 8'h00, 16'h00fe, 16'h0000, 16'h0ffe},
    '{3'h5, 4'h7, 4'h0, 8'h00, 16'h007f, 16'h0000, 16'h107f},
    '{3'h5, 4'h8, 4'h0, 8'h00, 16'h0080, 16'h0000, 16'h0f80},
    '{3'h5, 4'h9, 4'h0, 8'h00, 16'h0000, 16'h0000, 16'h1000},
    '{3'h5, 4'ha, 4'h0, 8'h00, 16'h0010, 16'h0000, 16'h1010},
    '{3'h2, 4'h0, 4'h0, 8'h00, 16'h00f0, 16'h0020, 16'h0010},
    '{3'h2, 4'h0, 4'h8, 8'h00, 16'h0080, 16'h0050, 16'h0001},
    '{3'h2, 4'h2, 4'h3, 8'h00, 16'h00f0, 16'h2000, 16'h1ff0},
    '{3'h2, 4'h1, 4'h1, 8'h00, 16'h0123, 16'h2000, 16'h2123},
    '{3'h1, 4'h0, 4'h0, 8'h40, 16'h0000, 16'h0000, 16'h0040},
    '{3'h1, 4'h0, 4'h8, 8'hc5, 16'h0000, 16'h0000, 16'h0001},
    '{3'h1, 4'h1, 4'h1, 8'h12, 16'h0000, 16'h0000, 16'h4812},
    '{3'h6, 4'hd, 4'h5, 8'h00, 16'hbeef, 16'h0000, 16'hbeef},
    '{3'h0, 4'h0, 4'h5, 8'h34, 16'h0000, 16'h0000, 16'h6e34},
    '{3'h0, 4'h0, 4'hc, 8'h06, 16'h0000, 16'h0000, 16'h0076},
    '{3'h0, 4'h0, 4'hc, 8'hcb, 16'h0000, 16'h0000, 16'h00ab},
    '{3'h2, 4'h3, 4'h8, 8'h00, 16'h0010, 16'h0000, 16'h0001}};
  always #12.5 clock_i = ~clock_i;
  oag_operand_address_generator u_oag_operand_address_generator (.clock_i(clock_i),
    .srst_i(srst_i), .req_i(req), .reg_data_i(reg_data), .index_data_i(index_data),
    .working_pointer_zero_i(8'h70), .working_pointer_one_i(8'ha8),
    .register_page_pointer_i(8'h00), .next_pc_i(16'h1000), .stack_load_i(stack_load_i),
    .stack_load_value_i(8'hff), .res_o(res_o), .stack_pointer_low_o(sp_o),
    .work_addr_o(work_addr));
  oag_regfile_model u_oag_regfile_model (.reg_field_i(req.reg_field), .reg_data_o(reg_data));
  // Compare one value and count the outcome.
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // A hang is cut short well past the roughly fifty cycles the run needs.
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    index_data = 16'h0000;
    repeat (10) @(negedge clock_i);
    srst_i = 1'b0;
    // Ordinary cases: one request per row, result checked one edge later.
    foreach (rows[k]) begin
      r = rows[k];
      req = '0;
      req.valid = 1'b1;
      req.mode = oag_pkg::oag_mode_t'(r.m);
      req.op = oag_pkg::oag_op_t'(r.o);
      req.pair = r.fl[0];
      req.short_offset = r.fl[1];
      req.working = (r.fl[3:2] == 2'h3);
      req.reg_field = r.rf;
      req.operand_field = r.opf;
      index_data = r.ix;
      @(negedge clock_i);
      case (r.fl[3:2])
        2'h0: seen = res_o.address;
        2'h1: seen = res_o.value;
        2'h2: seen = {15'h0000, res_o.blocked};
        default: seen = {8'h00, work_addr};
      endcase
      chk($sformatf("row %0d", k), r.e, seen);
    end
    // Back-to-back pushes then pops from a freshly loaded pointer.
    req = '0;
    stack_load_i = 1'b1;
    @(negedge clock_i);
    stack_load_i = 1'b0;
    for (int i = 0; i < 8; i++) begin
      req.valid = 1'b1;
      req.mode = oag_pkg::OAG_STACK_MODE;
      req.op = (i < 4) ? oag_pkg::OAG_PUSH_OP : oag_pkg::OAG_POP_OP;
      @(negedge clock_i);
      seen = {8'h00, (i < 4) ? 8'hfe - 8'(i) : 8'(i) + 8'hf7};
      chk("stack address", seen, {8'h00, res_o.address[7:0]});
    end
    req = '0;
    repeat (2) @(negedge clock_i);
    chk("stack restored", 16'h00ff, {8'h00, sp_o});
    // A push first moves the pointer off the top, so the reset below has to bring it back.
    req.valid = 1'b1;
    req.mode = oag_pkg::OAG_STACK_MODE;
    req.op = oag_pkg::OAG_PUSH_OP;
    @(negedge clock_i);
    req = '0;
    // A second reset in mid-run clears the result and reloads the pointer.
    srst_i = 1'b1;
    repeat (2) @(negedge clock_i);
    chk("reset valid", 16'h0000, {15'h0000, res_o.valid});
    chk("reset stack", 16'h00ff, {8'h00, sp_o});
    chk("reset work address", 16'h0000, {8'h00, work_addr});
    srst_i = 1'b0;
    // The first push after release must land one below the top again.
    req.valid = 1'b1;
    req.mode = oag_pkg::OAG_STACK_MODE;
    req.op = oag_pkg::OAG_PUSH_OP;
    @(negedge clock_i);
    req = '0;
    chk("first push address", 16'h00fe, res_o.address);
    chk("push space", {13'h0000, oag_pkg::OAG_SPACE_REGISTER}, {13'h0000, res_o.space});
    chk("push write", 16'h0001, {15'h0000, res_o.stack_write});
    repeat (2) @(negedge clock_i);
    chk("pointer after push", 16'h00fe, {8'h00, sp_o});
    close_out();
  end
endmodule // operand_address_generator_tb
